// >>> src/ssu_pkg.sv
// Purpose: Constants for the supply sense unit interrupt logic
// Assumes: APB, 32-bit data, one word per register
// Notes: Offsets are byte addresses
package ssu_pkg;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_IEN = 12'h008;
  localparam logic [11:0] OFF_FLAG = 12'h00C;
  // Control field positions
  localparam int CTRL_HSEL = 6;
  localparam int CTRL_LSEL_LO = 4;
  localparam int CTRL_ACON = 3;
  localparam int CTRL_LSEN = 2;
  // Status, enable and flag positions
  localparam int BIT_HIGH = 1;
  localparam int BIT_LOW = 0;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // Writable control bits; bits 1:0 are unused and stay zero
  localparam logic [6:0] CTRL_WMASK = 7'h7C;
  localparam logic [1:0] IEN_RST = 2'h0;
  localparam logic [1:0] FLAG_RST = 2'h0;
  typedef enum logic [1:0] {
    SSU_LOW_FIRST,
    SSU_LOW_SECOND,
    SSU_LOW_THIRD,
    SSU_LOW_FOURTH
  } ssu_low_level_t;
endpackage : ssu_pkg

// >>> src/ssu_supply_sense_unit.sv
// Purpose: Supply warning interrupt logic with APB register access
// Assumes: Comparator outputs asynchronous; APB slave with zero wait states
// Notes:
module ssu_supply_sense_unit (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cpu_run_mode,
  input wire logic low_cmp_async,
  input wire logic high_cmp_async,
  output logic [1:0] low_thresh_sel,
  output logic high_thresh_sel,
  output logic level_sense_en,
  output logic analog_channel_connect_en,
  output logic supply_warn_irq
);

  logic [6:0] ctrl_q;
  logic [1:0] ien_q;
  logic [1:0] flag_q;
  logic [1:0] flag_d;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] stat_q;
  logic [1:0] cond_d;
  logic [1:0] change;
  logic [1:0] clr;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] rdata_d;
  logic low_cond_irq_src;
  logic high_cond_irq_src;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == ssu_pkg::OFF_CTRL) || (paddr == ssu_pkg::OFF_STAT) ||
                   (paddr == ssu_pkg::OFF_IEN) || (paddr == ssu_pkg::OFF_FLAG);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Control register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_q <= ssu_pkg::CTRL_RST;
    end else if (wr_en && paddr == ssu_pkg::OFF_CTRL && pstrb[0]) begin
      ctrl_q <= pwdata[6:0] & ssu_pkg::CTRL_WMASK;
    end
  end

  assign low_thresh_sel = ctrl_q[ssu_pkg::CTRL_LSEL_LO +: 2];
  assign high_thresh_sel = ctrl_q[ssu_pkg::CTRL_HSEL];
  assign analog_channel_connect_en = ctrl_q[ssu_pkg::CTRL_ACON];
  assign level_sense_en = ctrl_q[ssu_pkg::CTRL_LSEN];

  // Interrupt enable register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ien_q <= ssu_pkg::IEN_RST;
    end else if (wr_en && paddr == ssu_pkg::OFF_IEN && pstrb[0]) begin
      ien_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {high_cmp_async, low_cmp_async};
      sync2_q <= sync1_q;
    end
  end

  // force zero when sensing is off
  assign cond_d = level_sense_en ? sync2_q : 2'h0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= cond_d;
    end
  end

  assign change = stat_q ^ cond_d;
  assign clr = (wr_en && paddr == ssu_pkg::OFF_FLAG && pstrb[0]) ? pwdata[1:0] : 2'h0;

  always_comb begin
    flag_d = (flag_q & ~clr) | change;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= ssu_pkg::FLAG_RST;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign low_cond_irq_src = flag_q[ssu_pkg::BIT_LOW] && ien_q[ssu_pkg::BIT_LOW];
  assign high_cond_irq_src = flag_q[ssu_pkg::BIT_HIGH] && ien_q[ssu_pkg::BIT_HIGH];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      supply_warn_irq <= 1'b0;
    end else begin
      supply_warn_irq <= cpu_run_mode && (low_cond_irq_src || high_cond_irq_src);
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      ssu_pkg::OFF_CTRL: rdata_d[6:0] = ctrl_q;
      ssu_pkg::OFF_STAT: rdata_d[1:0] = stat_q;
      ssu_pkg::OFF_IEN: rdata_d[1:0] = ien_q;
      ssu_pkg::OFF_FLAG: rdata_d[1:0] = flag_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_d;
    end
  end

  // Assertions
  // forced zero status
  a_force_zero: assert property (@(posedge clk_sys) disable iff (srst)
    !level_sense_en |=> stat_q == 2'h0)
    else $error("status not forced to zero");
  a_no_sense_flag: assert property (@(posedge clk_sys) disable iff (srst)
    (!level_sense_en && stat_q == 2'h0) |=> (flag_q & ~$past(flag_q)) == 2'h0)
    else $error("flag set while sensing off");
  a_sense_fwd: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && paddr == ssu_pkg::OFF_CTRL && pstrb[0]) |=> level_sense_en == $past(pwdata[ssu_pkg::CTRL_LSEN]))
    else $error("sense enable not written");

  a_low_set: assert property (@(posedge clk_sys) disable iff (srst)
    change[0] |=> flag_q[0])
    else $error("low flag missed a change");
  a_high_set: assert property (@(posedge clk_sys) disable iff (srst)
    change[1] |=> flag_q[1])
    else $error("high flag missed a change");
  // low flag falls only on clear
  a_low_clear: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(flag_q[0]) |-> $past(clr[0]))
    else $error("low flag fell without clear");
  // high flag falls only on clear
  a_high_clear: assert property (@(posedge clk_sys) disable iff (srst)
    $fell(flag_q[1]) |-> $past(clr[1]))
    else $error("high flag fell without clear");
  a_low_w0: assert property (@(posedge clk_sys) disable iff (srst)
    (!clr[0] && flag_q[0]) |=> flag_q[0])
    else $error("low flag lost without clear");
  a_high_w0: assert property (@(posedge clk_sys) disable iff (srst)
    (!clr[1] && flag_q[1]) |=> flag_q[1])
    else $error("high flag lost without clear");
  a_low_w1: assert property (@(posedge clk_sys) disable iff (srst)
    (clr[0] && !change[0]) |=> !flag_q[0])
    else $error("low flag not cleared");
  a_high_w1: assert property (@(posedge clk_sys) disable iff (srst)
    (clr[1] && !change[1]) |=> !flag_q[1])
    else $error("high flag not cleared");

  a_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
    (clr[0] && change[0]) |=> flag_q[0])
    else $error("clear beat set");
  a_set_wins_high: assert property (@(posedge clk_sys) disable iff (srst)
    (clr[1] && change[1]) |=> flag_q[1])
    else $error("clear beat high set");

  a_irq_low: assert property (@(posedge clk_sys) disable iff (srst)
    (flag_q[0] && ien_q[0] && cpu_run_mode) |=> supply_warn_irq)
    else $error("low request missing");
  a_irq_high: assert property (@(posedge clk_sys) disable iff (srst)
    (flag_q[1] && ien_q[1] && cpu_run_mode) |=> supply_warn_irq)
    else $error("high request missing");
  a_irq_cause: assert property (@(posedge clk_sys) disable iff (srst)
    supply_warn_irq |-> $past(cpu_run_mode && (low_cond_irq_src || high_cond_irq_src)))
    else $error("request without masked source");
  a_irq_none: assert property (@(posedge clk_sys) disable iff (srst)
    (!low_cond_irq_src && !high_cond_irq_src) |=> !supply_warn_irq)
    else $error("request without any source");
  a_low_mask: assert property (@(posedge clk_sys) disable iff (srst)
    !ien_q[0] |-> !low_cond_irq_src)
    else $error("low source passed its mask");
  a_high_mask: assert property (@(posedge clk_sys) disable iff (srst)
    !ien_q[1] |-> !high_cond_irq_src)
    else $error("high source passed its mask");
  a_ien_hold: assert property (@(posedge clk_sys) disable iff (srst)
    !(wr_en && paddr == ssu_pkg::OFF_IEN && pstrb[0]) |=> $stable(ien_q))
    else $error("enables changed without write");

  a_irq_stop: assert property (@(posedge clk_sys) disable iff (srst)
    !cpu_run_mode |=> !supply_warn_irq)
    else $error("request outside run mode");
  a_flag_keep_mode: assert property (@(posedge clk_sys) disable iff (srst)
    ($changed(cpu_run_mode) && change == 2'h0 && clr == 2'h0) |=> flag_q == $past(flag_q))
    else $error("flags moved on mode change");

  a_low_sel_fwd: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && paddr == ssu_pkg::OFF_CTRL && pstrb[0]) |=> low_thresh_sel == $past(pwdata[5:4]))
    else $error("low select not written");
  a_high_sel_fwd: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && paddr == ssu_pkg::OFF_CTRL && pstrb[0]) |=> high_thresh_sel == $past(pwdata[6]))
    else $error("high select not written");
  a_connect_fwd: assert property (@(posedge clk_sys) disable iff (srst)
    (wr_en && paddr == ssu_pkg::OFF_CTRL && pstrb[0]) |=> analog_channel_connect_en == $past(pwdata[3]))
    else $error("connect bit not written");

  a_low_status: assert property (@(posedge clk_sys) disable iff (srst)
    level_sense_en |=> stat_q[0] == $past(sync2_q[0]))
    else $error("low status wrong");
  a_high_status: assert property (@(posedge clk_sys) disable iff (srst)
    level_sense_en |=> stat_q[1] == $past(sync2_q[1]))
    else $error("high status wrong");
  a_sync_stage: assert property (@(posedge clk_sys) disable iff (srst)
    1'b1 |=> sync2_q == $past(sync1_q))
    else $error("second stage out of step");
  a_sync_delay: assert property (@(posedge clk_sys) disable iff (srst)
    (level_sense_en && $past(level_sense_en, 1)) |-> ##1 stat_q == $past(sync1_q, 2))
    else $error("synchroniser latency wrong");

  a_sense_off_flag: assert property (@(posedge clk_sys) disable iff (srst)
    ($fell(level_sense_en) && stat_q[0]) |=> flag_q[0])
    else $error("disable did not set low flag");
  a_sense_off_high: assert property (@(posedge clk_sys) disable iff (srst)
    ($fell(level_sense_en) && stat_q[1]) |=> flag_q[1])
    else $error("disable did not set high flag");

  a_rd_unused: assert property (@(posedge clk_sys) disable iff (srst)
    (psel && !penable && !pwrite) |=> prdata[31:7] == 25'h0)
    else $error("unused read bits set");
  a_ctrl_unused: assert property (@(posedge clk_sys) disable iff (srst)
    ctrl_q[1:0] == 2'h0)
    else $error("unused control bits set");
  a_slverr_map: assert property (@(posedge clk_sys) disable iff (srst)
    (psel && penable && addr_ok) |-> !pslverr)
    else $error("error on mapped address");

  c_low_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(flag_q[0]) ##1 supply_warn_irq);
  c_high_irq: cover property (@(posedge clk_sys) disable iff (srst) $rose(flag_q[1]) ##1 supply_warn_irq);
  c_set_clear: cover property (@(posedge clk_sys) disable iff (srst) clr[0] && change[0]);
  c_sense_off: cover property (@(posedge clk_sys) disable iff (srst) $fell(level_sense_en) && stat_q != 2'h0);
  c_low_off: cover property (@(posedge clk_sys) disable iff (srst) $fell(level_sense_en) && stat_q[0]);

endmodule : ssu_supply_sense_unit

// >>> tb/ssu_cmp_model.sv
// Purpose: Behavioural supply comparators
// Assumes: Supply given as an abstract level
// Notes: No hysteresis; outputs move off the clock edge
module ssu_cmp_model (
  input wire logic [7:0] supply_lvl,
  input wire logic [1:0] low_thresh_sel,
  input wire logic high_thresh_sel,
  output logic low_cmp_async,
  output logic high_cmp_async
);
  timeunit 1ns;
  timeprecision 1ps;
  assign #3 low_cmp_async = supply_lvl < 8'h0A * (8'h01 + low_thresh_sel);
  assign #3 high_cmp_async = supply_lvl >= (high_thresh_sel ? 8'h46 : 8'h3C);
endmodule : ssu_cmp_model

// >>> tb/supply_voltage_warning_irq_bench.sv
// Purpose: Self-checking bench for the supply sense unit
// Assumes: Low levels 10,20,30,40 and high levels 60,70
// Notes: Register rows first, then flag cases
module supply_voltage_warning_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cpu_run_mode = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [7:0] supply_lvl = 8'h32;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, low_cmp_async, high_cmp_async;
  logic level_sense_en, analog_channel_connect_en, high_thresh_sel, supply_warn_irq;
  logic [1:0] low_thresh_sel;
  int miscompares = 0;
  int checked = 0;
  logic [6:0] rows [5] = '{7'h00, 7'h10, 7'h24, 7'h38, 7'h4C};
  always #4 clk_sys = ~clk_sys;
  ssu_supply_sense_unit u_ssu_supply_sense_unit (.*);
  ssu_cmp_model u_ssu_cmp_model (.*);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk
  task automatic irqchk(input string nm, input logic exp);
    repeat (2) @(posedge clk_sys);
    chk(nm, {31'h0, exp}, {31'h0, supply_warn_irq});
  endtask : irqchk
  task automatic results;
    if (miscompares == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  initial begin
    #30000;
    miscompares++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 16; i += 4) rdchk("reset", 12'(i), 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, ssu_pkg::OFF_CTRL, 32'hFFFFFF83 | rows[i]);
      rdchk("ctrl", ssu_pkg::OFF_CTRL, {25'h0, rows[i]});
      chk("pins", {27'h0, rows[i][6:2]}, {27'h0, high_thresh_sel, low_thresh_sel,
        analog_channel_connect_en, level_sense_en});
    end
    apb(1'b1, ssu_pkg::OFF_CTRL, 32'h04);
    supply_lvl <= 8'h05;
    repeat (5) @(posedge clk_sys);
    rdchk("stat low", ssu_pkg::OFF_STAT, 32'h1);
    rdchk("flag low", ssu_pkg::OFF_FLAG, 32'h1);
    irqchk("irq masked", 1'b0);
    apb(1'b1, ssu_pkg::OFF_IEN, 32'h1);
    irqchk("irq low", 1'b1);
    cpu_run_mode <= 1'b0;
    irqchk("irq stop", 1'b0);
    cpu_run_mode <= 1'b1;
    apb(1'b1, ssu_pkg::OFF_FLAG, 32'h0);
    rdchk("flag w0", ssu_pkg::OFF_FLAG, 32'h1);
    apb(1'b1, ssu_pkg::OFF_FLAG, 32'h1);
    rdchk("flag w1", ssu_pkg::OFF_FLAG, 32'h0);
    irqchk("irq clr", 1'b0);
    apb(1'b1, ssu_pkg::OFF_IEN, 32'h2);
    supply_lvl <= 8'h41;
    repeat (5) @(posedge clk_sys);
    rdchk("stat high", ssu_pkg::OFF_STAT, 32'h2);
    rdchk("flag both", ssu_pkg::OFF_FLAG, 32'h3);
    irqchk("irq high", 1'b1);
    apb(1'b1, ssu_pkg::OFF_FLAG, 32'h3);
    rdchk("flag clr", ssu_pkg::OFF_FLAG, 32'h0);
    apb(1'b1, ssu_pkg::OFF_CTRL, 32'h44);
    repeat (5) @(posedge clk_sys);
    rdchk("stat sel", ssu_pkg::OFF_STAT, 32'h0);
    rdchk("flag sel", ssu_pkg::OFF_FLAG, 32'h2);
    apb(1'b1, ssu_pkg::OFF_CTRL, 32'h04);
    repeat (5) @(posedge clk_sys);
    apb(1'b1, ssu_pkg::OFF_FLAG, 32'h3);
    // Sense dropped with enables left on: extra event expected
    apb(1'b1, ssu_pkg::OFF_CTRL, 32'h00);
    repeat (5) @(posedge clk_sys);
    rdchk("stat off", ssu_pkg::OFF_STAT, 32'h0);
    rdchk("flag off", ssu_pkg::OFF_FLAG, 32'h2);
    irqchk("irq off", 1'b1);
    apb(1'b1, ssu_pkg::OFF_IEN, 32'h0);
    supply_lvl <= 8'h05;
    apb(1'b1, ssu_pkg::OFF_CTRL, 32'h04);
    repeat (5) @(posedge clk_sys);
    apb(1'b1, ssu_pkg::OFF_FLAG, 32'h3);
    // Enables cleared first: drop of sense stays quiet
    apb(1'b1, ssu_pkg::OFF_CTRL, 32'h00);
    repeat (5) @(posedge clk_sys);
    rdchk("flag low off", ssu_pkg::OFF_FLAG, 32'h1);
    irqchk("irq quiet", 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    results();
  end
endmodule : supply_voltage_warning_irq_bench
